// File: design/tds_diag_bank.v
// Diagnostic status/control and alarm/warning flag bank with two-wire slave.
// Assumes open-drain SDA/SCL pins resolved outside; monitor data on sys_clk.
//
// How it works
// - Status bit 7 reads the synchronised transmitter-disable pin level.
// - Status bit 6 is the readable and writable soft transmitter-disable bit.
// - Transmitter disabled when soft bit or pin is high.
// - Status bit 4 reads the synchronised rate-select pin level.
// - Status bit 3 is the readable and writable soft rate-select bit.
// - Effective rate select is soft bit OR pin; high means high rate.
// - High rate optimises 4.25/2.125 Gb/s, low rate 2.125/1.0625 Gb/s.
// - Status bit 2 reads the transmitter fault pin level.
// - Status bit 1 reads the receive loss-of-signal pin level.
// - Status bit 0 reads 0 when powered and monitor data valid.
// - Soft control writes act on outputs well within 100 ms.
// - alarm_flags_high bits 7/6 are temperature high/low alarms.
// - alarm_flags_high bits 5/4 are supply voltage high/low alarms.
// - alarm_flags_high bits 3/2 are laser bias high/low alarms.
// - alarm_flags_high bits 1/0 are transmit power high/low alarms.
// - alarm_flags_low bits 7/6 are receive power alarms; rest reserved.
// - warning_flags_high bits 7..4 are temperature and supply warnings.
// - warning_flags_high bits 3..0 are bias and transmit power warnings.
// - warning_flags_low bits 7/6 are receive power warnings; rest reserved.
// - Temperature values and limits are signed, 1/256 degree steps.
// - Live temperature reads MSB first at bytes 96 and 97.
`timescale 1ns/100ps
`default_nettype none
`include "tds_consts.vh"

module tds_diag_bank #(
    parameter       NCH      = `TDS_NUM_CHAN,
    parameter       W        = `TDS_VAL_W,
    parameter [6:0] DEV_ADDR = `TDS_DEV_ADDR
) (
    // Clock and reset
    input  wire             sys_clk,
    input  wire             rst,
    // Two-wire management pins
    input  wire             scl_in,
    input  wire             sda_in,
    output wire             sda_out,
    output wire             sda_oe_n,
    // Module pins
    input  wire             tx_disable_pin,
    input  wire             rate_select_pin,
    input  wire             tx_fault_pin_level,
    input  wire             receive_signal_lost_pin_level,
    input  wire             monitor_ready,
    // Live values and limits, channel k at bits k*W: temp, vcc, bias, tx, rx
    input  wire [NCH*W-1:0] monitor_values,
    input  wire [NCH*W-1:0] alarm_hi_limits,
    input  wire [NCH*W-1:0] alarm_lo_limits,
    input  wire [NCH*W-1:0] warn_hi_limits,
    input  wire [NCH*W-1:0] warn_lo_limits,
    // Effective controls
    output reg              tx_disabled_q,
    output reg              rate_high_q
);

    // One-hot states of the serial slave
    localparam [8:0] ST_IDLE  = 9'h001;
    localparam [8:0] ST_ADDR  = 9'h002;
    localparam [8:0] ST_AACK  = 9'h004;
    localparam [8:0] ST_OFS   = 9'h008;
    localparam [8:0] ST_OACK  = 9'h010;
    localparam [8:0] ST_DATA  = 9'h020;
    localparam [8:0] ST_DACK  = 9'h040;
    localparam [8:0] ST_TX    = 9'h080;
    localparam [8:0] ST_RACK  = 9'h100;

    wire [5:0]       pins_s;
    wire             scl_s;
    wire             sda_s;
    wire             txdis_pin_s;
    wire             rate_pin_s;
    wire             fault_s;
    wire             los_s;
    wire [4*NCH-1:0] flags;
    wire [7:0]       status_byte;
    wire [7:0]       alarm_hi_byte;
    wire [7:0]       alarm_lo_byte;
    wire [7:0]       warn_hi_byte;
    wire [7:0]       warn_lo_byte;
    wire [7:0]       offset_inc;
    wire [7:0]       live_rel;
    wire [W-1:0]     live_word;
    wire             start_cond;
    wire             stop_cond;
    wire             scl_rise;
    wire             scl_fall;

    reg  [8:0]       state_q;
    reg  [3:0]       cnt_q;
    reg  [7:0]       shift_q;
    reg  [7:0]       tx_q;
    reg  [7:0]       offset_q;
    reg              rw_q;
    reg              sda_low_q;
    reg              scl_prev_q;
    reg              sda_prev_q;
    reg              soft_txdis_q;
    reg              soft_rate_q;
    reg              ready_q;
    reg  [7:0]       rd_byte;

    tds_sync #(
        .WIDTH (6)
    ) u_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in ({scl_in, sda_in, tx_disable_pin, rate_select_pin,
                    tx_fault_pin_level, receive_signal_lost_pin_level}),
        .sync_out (pins_s)
    );

    assign scl_s       = pins_s[5];
    assign sda_s       = pins_s[4];
    assign txdis_pin_s = pins_s[3];
    assign rate_pin_s  = pins_s[2];
    assign fault_s     = pins_s[1];
    assign los_s       = pins_s[0];

    // One comparator per monitored quantity
    genvar c;
    generate
        for (c = 0; c < NCH; c = c + 1) begin : g_chan
            tds_limit_check #(
                .IS_SIGNED (c == `TDS_CHAN_TEMP),
                .W         (W)
            ) u_check (
                .sys_clk  (sys_clk),
                .rst      (rst),
                .value    (monitor_values[c*W +: W]),
                .alarm_hi (alarm_hi_limits[c*W +: W]),
                .alarm_lo (alarm_lo_limits[c*W +: W]),
                .warn_hi  (warn_hi_limits[c*W +: W]),
                .warn_lo  (warn_lo_limits[c*W +: W]),
                .flags_q  (flags[c*4 +: 4])
            );
        end
    endgenerate

    assign alarm_hi_byte = {flags[3], flags[2], flags[7], flags[6],
                            flags[11], flags[10], flags[15], flags[14]};
    assign alarm_lo_byte = {flags[19], flags[18], 6'h00};
    assign warn_hi_byte  = {flags[1], flags[0], flags[5], flags[4],
                            flags[9], flags[8], flags[13], flags[12]};
    assign warn_lo_byte  = {flags[17], flags[16], 6'h00};

    assign status_byte = {txdis_pin_s, soft_txdis_q, 1'b0, rate_pin_s,
                          soft_rate_q, fault_s, los_s, ~ready_q};

    // Ready flag registered from the monitor front end
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= monitor_ready;
        end
    end

    assign live_rel  = offset_q - `TDS_OFS_LIVE_FIRST;
    assign live_word = monitor_values[live_rel[3:1]*W +: W];

    always @* begin
        rd_byte = 8'h00;
        case (offset_q)
            `TDS_OFS_STATUS:   rd_byte = status_byte;
            `TDS_OFS_ALARM_HI: rd_byte = alarm_hi_byte;
            `TDS_OFS_ALARM_LO: rd_byte = alarm_lo_byte;
            `TDS_OFS_WARN_HI:  rd_byte = warn_hi_byte;
            `TDS_OFS_WARN_LO:  rd_byte = warn_lo_byte;
            default: begin
                if (offset_q >= `TDS_OFS_LIVE_FIRST && offset_q <= `TDS_OFS_LIVE_LAST) begin
                    rd_byte = live_rel[0] ? live_word[7:0] : live_word[15:8];
                end
            end
        endcase
    end

    // Bus condition detection
    assign start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_cond  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    assign scl_rise   = scl_s & ~scl_prev_q;
    assign scl_fall   = ~scl_s & scl_prev_q;
    assign offset_inc = offset_q + 8'h01;

    // Open drain: only ever pulls low
    assign sda_out  = 1'b0;
    assign sda_oe_n = ~sda_low_q;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    // Serial slave state machine
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q      <= ST_IDLE;
            cnt_q        <= 4'h0;
            shift_q      <= 8'h00;
            tx_q         <= 8'h00;
            offset_q     <= 8'h00;
            rw_q         <= 1'b0;
            sda_low_q    <= 1'b0;
            soft_txdis_q <= `TDS_RST_SOFT_TXDIS;
            soft_rate_q  <= `TDS_RST_SOFT_RATE;
        end else if (start_cond) begin
            state_q   <= ST_ADDR;
            cnt_q     <= 4'h0;
            sda_low_q <= 1'b0;
        end else if (stop_cond) begin
            state_q   <= ST_IDLE;
            sda_low_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    sda_low_q <= 1'b0;
                end
                ST_ADDR, ST_OFS, ST_DATA: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_s};
                        cnt_q   <= cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == 4'h8) begin
                        cnt_q <= 4'h0;
                        if (state_q == ST_ADDR) begin
                            if (shift_q[7:1] == DEV_ADDR) begin
                                rw_q      <= shift_q[0];
                                sda_low_q <= 1'b1;
                                state_q   <= ST_AACK;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end else if (state_q == ST_OFS) begin
                            offset_q  <= shift_q;
                            sda_low_q <= 1'b1;
                            state_q   <= ST_OACK;
                        end else begin
                            if (offset_q == `TDS_OFS_STATUS) begin
                                soft_txdis_q <= shift_q[`TDS_BIT_TXDIS_SOFT];
                                soft_rate_q  <= shift_q[`TDS_BIT_RATE_SOFT];
                            end
                            offset_q  <= offset_inc;
                            sda_low_q <= 1'b1;
                            state_q   <= ST_DACK;
                        end
                    end
                end
                ST_AACK: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            tx_q      <= rd_byte;
                            sda_low_q <= ~rd_byte[7];
                            offset_q  <= offset_inc;
                            state_q   <= ST_TX;
                        end else begin
                            sda_low_q <= 1'b0;
                            state_q   <= ST_OFS;
                        end
                    end
                end
                ST_OACK, ST_DACK: begin
                    if (scl_fall) begin
                        sda_low_q <= 1'b0;
                        state_q   <= ST_DATA;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_q == 4'h7) begin
                            cnt_q     <= 4'h0;
                            sda_low_q <= 1'b0;
                            state_q   <= ST_RACK;
                        end else begin
                            cnt_q     <= cnt_q + 4'h1;
                            tx_q      <= {tx_q[6:0], 1'b0};
                            sda_low_q <= ~tx_q[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        rw_q <= ~sda_s;
                    end else if (scl_fall) begin
                        if (rw_q) begin
                            tx_q      <= rd_byte;
                            sda_low_q <= ~rd_byte[7];
                            offset_q  <= offset_inc;
                            state_q   <= ST_TX;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_q   <= ST_IDLE;
                    sda_low_q <= 1'b0;
                end
            endcase
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_disabled_q <= 1'b0;
            rate_high_q   <= 1'b0;
        end else begin
            tx_disabled_q <= soft_txdis_q | txdis_pin_s;
            rate_high_q   <= soft_rate_q | rate_pin_s;
        end
    end

endmodule

`default_nettype wire

// File: shared/tds_consts.vh
// Constants for the transceiver diagnostic status and flag bank.
// Assumes inclusion by bare name from the design files and the bench.
`ifndef TDS_CONSTS_VH
`define TDS_CONSTS_VH

// Two-wire slave address of the diagnostic page, 7-bit form
`define TDS_DEV_ADDR        7'h51

// Register byte offsets on the diagnostic page
`define TDS_OFS_STATUS      8'h6e
`define TDS_OFS_ALARM_HI    8'h70
`define TDS_OFS_ALARM_LO    8'h71
`define TDS_OFS_WARN_HI     8'h74
`define TDS_OFS_WARN_LO     8'h75
`define TDS_OFS_LIVE_FIRST  8'h60
`define TDS_OFS_LIVE_LAST   8'h69

// Status/control byte field positions
`define TDS_BIT_TXDIS_PIN   7
`define TDS_BIT_TXDIS_SOFT  6
`define TDS_BIT_RATE_PIN    4
`define TDS_BIT_RATE_SOFT   3
`define TDS_BIT_FAULT_PIN   2
`define TDS_BIT_LOS_PIN     1
`define TDS_BIT_NOT_READY   0

// Reset values
`define TDS_RST_SOFT_TXDIS  1'b0
`define TDS_RST_SOFT_RATE   1'b0
`define TDS_RST_FLAGS       4'h0

// Monitored quantities
`define TDS_NUM_CHAN        5
`define TDS_VAL_W           16
`define TDS_CHAN_TEMP       0

// Soft command response bound, milliseconds
`define TDS_RESPONSE_MS     100

`endif

// File: design/tds_sync.v
// Two flip-flop synchroniser, one lane per bit.
// Assumes inputs come from pins outside the sys_clk domain.
`timescale 1ns/100ps
`default_nettype none

module tds_sync #(
    parameter WIDTH = 6
) (
    // Clock and reset
    input  wire             sys_clk,
    input  wire             rst,
    // Lanes
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
            reg meta_q;
            reg stable_q;
            always @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    meta_q   <= 1'b0;
                    stable_q <= 1'b0;
                end else begin
                    meta_q   <= async_in[i];
                    stable_q <= meta_q;
                end
            end
            assign sync_out[i] = stable_q;
        end
    endgenerate

endmodule

`default_nettype wire

// File: design/tds_limit_check.v
// Threshold comparison for one monitored quantity.
// Assumes value and thresholds come from logic on sys_clk.
`timescale 1ns/100ps
`default_nettype none
`include "tds_consts.vh"

module tds_limit_check #(
    parameter IS_SIGNED = 0,
    parameter W         = 16
) (
    // Clock and reset
    input  wire         sys_clk,
    input  wire         rst,
    // Live value and limits
    input  wire [W-1:0] value,
    input  wire [W-1:0] alarm_hi,
    input  wire [W-1:0] alarm_lo,
    input  wire [W-1:0] warn_hi,
    input  wire [W-1:0] warn_lo,
    // Flags: alarm high, alarm low, warning high, warning low
    output reg  [3:0]   flags_q
);

    wire [W:0] v_x;
    wire [W:0] ah_x;
    wire [W:0] al_x;
    wire [W:0] wh_x;
    wire [W:0] wl_x;

    // Signed or unsigned compare, per IS_SIGNED
    // Signed quantities get an inverted top bit so unsigned compare orders them
    assign v_x  = {1'b0, value[W-1]    ^ (IS_SIGNED != 0), value[W-2:0]};
    assign ah_x = {1'b0, alarm_hi[W-1] ^ (IS_SIGNED != 0), alarm_hi[W-2:0]};
    assign al_x = {1'b0, alarm_lo[W-1] ^ (IS_SIGNED != 0), alarm_lo[W-2:0]};
    assign wh_x = {1'b0, warn_hi[W-1]  ^ (IS_SIGNED != 0), warn_hi[W-2:0]};
    assign wl_x = {1'b0, warn_lo[W-1]  ^ (IS_SIGNED != 0), warn_lo[W-2:0]};

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flags_q <= `TDS_RST_FLAGS;
        end else begin
            flags_q <= {v_x > ah_x, v_x < al_x, v_x > wh_x, v_x < wl_x};
        end
    end

endmodule

`default_nettype wire

// File: tb/tds_monitor.sv
// Port checker for the diagnostic status and flag bank.
// Assumes binding to tds_diag_bank; single sys_clk domain.
`timescale 1ns/100ps
`default_nettype none
module tds_monitor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Bus and pins
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic tx_disable_pin,
    input wire logic rate_select_pin,
    // Effective controls
    input wire logic tx_disabled_q,
    input wire logic rate_high_q
);
    default clocking tds_cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_txd_hi; tx_disable_pin [*4]; endsequence
    sequence s_rate_hi; rate_select_pin [*4]; endsequence
    sequence s_ack_go; $fell(sda_oe_n); endsequence
    property p_txd_pin; s_txd_hi |-> tx_disabled_q; endproperty
    property p_txd_fall; $fell(tx_disabled_q) |-> !$past(tx_disable_pin, 3); endproperty
    property p_rate_pin; s_rate_hi |-> rate_high_q; endproperty
    property p_rate_fall; $fell(rate_high_q) |-> !$past(rate_select_pin, 3); endproperty
    property p_oe_stable; scl_in [*4] |-> $stable(sda_oe_n); endproperty
    property p_oe_bound; s_ack_go |-> ##[1:400] sda_oe_n; endproperty
    property p_rst_out; $fell(rst) |-> !tx_disabled_q && !rate_high_q; endproperty
    property p_sda_zero; !sda_oe_n |-> !sda_out; endproperty
    property p_oe_scl_low; $changed(sda_oe_n) |-> !scl_in; endproperty
    a_txd_pin: assert property (p_txd_pin) else $error("pin disable lost");
    a_txd_fall: assert property (p_txd_fall) else $error("disable dropped");
    a_rate_pin: assert property (p_rate_pin) else $error("pin rate lost");
    a_rate_fall: assert property (p_rate_fall) else $error("rate dropped");
    a_oe_stable: assert property (p_oe_stable) else $error("sda moved");
    a_oe_bound: assert property (p_oe_bound) else $error("sda stuck");
    a_rst_out: assert property (p_rst_out) else $error("reset value");
    a_sda_zero: assert property (p_sda_zero) else $error("sda high");
    a_oe_scl_low: assert property (p_oe_scl_low) else $error("sda moved, scl high");
endmodule
`default_nettype wire

// File: tb/tds_host.sv
// Two-wire host controller model driving the management bus.
// Assumes a pull-up on SDA resolved by the bench.
`timescale 1ns/100ps
`default_nettype none
module tds_host (
    // Clock
    input wire logic sys_clk,
    // Bus lines
    input wire logic sda_line,
    output logic     scl,
    output logic     sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic start();
        w(5);
        sda_low = 1'b0;
        w(5);
        scl = 1'b1;
        w(10);
        sda_low = 1'b1;
        w(10);
        scl = 1'b0;
    endtask
    task automatic stop();
        w(5);
        sda_low = 1'b1;
        w(5);
        scl = 1'b1;
        w(10);
        sda_low = 1'b0;
        w(10);
    endtask
    task automatic xfer(input logic [7:0] d, input logic a9, output logic [7:0] q,
                        output logic ao);
        logic [8:0] s;
        logic [8:0] r;
        s = {d, a9};
        for (int i = 8; i >= 0; i--) begin
            w(5);
            sda_low = !s[i];
            w(5);
            scl = 1'b1;
            w(10);
            r[i] = sda_line;
            scl = 1'b0;
        end
        q = r[8:1];
        ao = r[0];
    endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the diagnostic bank.
// Assumes tds_host as bus partner and tds_monitor bound to tds_diag_bank.
`timescale 1ns/100ps
`default_nettype none
`include "tds_consts.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        tx_pin = 1'b0, rate_pin = 1'b0, flt_pin = 1'b0, los_pin = 1'b0, rdy = 1'b0;
    logic [79:0] mv = '0, ahl = '0, all = '0, whl = '0, wll = '0;
    logic [7:0]  rbuf [0:7];
    logic [3:0]  f [0:4];
    logic        soft_t, soft_r, ack;
    logic [7:0]  d, q;
    integer      seed, n_fail = 0, n_checks = 0, cyc = 0;
    wire         scl, h_low, sda_oe_n, sda_out, tx_dis, rate_hi;
    wire         sda_line = !(h_low || (!sda_oe_n && !sda_out));
    always #10 sys_clk = ~sys_clk;
    tds_host u_host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_low(h_low));
    tds_diag_bank u_dut (
        .sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .tx_disable_pin(tx_pin),
        .rate_select_pin(rate_pin), .tx_fault_pin_level(flt_pin),
        .receive_signal_lost_pin_level(los_pin), .monitor_ready(rdy),
        .monitor_values(mv), .alarm_hi_limits(ahl), .alarm_lo_limits(all),
        .warn_hi_limits(whl), .warn_lo_limits(wll),
        .tx_disabled_q(tx_dis), .rate_high_q(rate_hi));
    function automatic logic [3:0] cf(input int k);
        logic [15:0] v, a, b, c, e;
        v = mv[k*16+:16];
        a = ahl[k*16+:16];
        b = all[k*16+:16];
        c = whl[k*16+:16];
        e = wll[k*16+:16];
        if (k == 0) return {$signed(v) > $signed(a), $signed(v) < $signed(b),
                            $signed(v) > $signed(c), $signed(v) < $signed(e)};
        return {v > a, v < b, v > c, v < e};
    endfunction
    task automatic tally_and_finish();
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
        u_host.start();
        u_host.xfer({`TDS_DEV_ADDR, 1'b0}, 1'b1, q, ack);
        `CHK(ack, 1'b0)
        u_host.xfer(ofs, 1'b1, q, ack);
        u_host.xfer(v, 1'b1, q, ack);
        u_host.stop();
    endtask
    task automatic rd(input logic [7:0] ofs, input int n);
        u_host.start();
        u_host.xfer({`TDS_DEV_ADDR, 1'b0}, 1'b1, q, ack);
        u_host.xfer(ofs, 1'b1, q, ack);
        u_host.start();
        u_host.xfer({`TDS_DEV_ADDR, 1'b1}, 1'b1, q, ack);
        for (int i = 0; i < n; i++) begin
            u_host.xfer(8'hff, i == n - 1, q, ack);
            rbuf[i] = q;
        end
        u_host.stop();
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 80000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        seed = 32'ha5fc_aebf;
        repeat (20) @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge sys_clk);
        // Foreign address must not be acknowledged
        u_host.start();
        u_host.xfer(8'ha0, 1'b1, q, ack);
        `CHK(ack, 1'b1)
        u_host.stop();
        for (int it = 0; it < 8; it++) begin
            @(posedge sys_clk);
            #1;
            {tx_pin, rate_pin, flt_pin, los_pin, rdy} = 5'($random(seed));
            for (int k = 0; k < 5; k++) begin
                mv[k*16+:16] = 16'($random(seed));
                ahl[k*16+:16] = 16'($random(seed));
                all[k*16+:16] = 16'($random(seed));
                whl[k*16+:16] = 16'($random(seed));
                wll[k*16+:16] = 16'($random(seed));
            end
            if (it == 0) {ahl, all, whl, wll} = {mv, mv, mv, mv};
            if (it == 1) {mv[15:0], ahl[15:0], all[15:0]} = {16'hff00, 16'h0100, 16'h0000};
            d = 8'($random(seed));
            wr(`TDS_OFS_STATUS, d);
            soft_t = d[6];
            soft_r = d[3];
            wr(`TDS_OFS_ALARM_HI, 8'($random(seed)));
            rd(`TDS_OFS_STATUS, 1);
            `CHK(rbuf[0], {tx_pin, soft_t, 1'b0, rate_pin, soft_r, flt_pin, los_pin, ~rdy})
            `CHK(tx_dis, tx_pin | soft_t)
            `CHK(rate_hi, rate_pin | soft_r)
            for (int k = 0; k < 5; k++) f[k] = cf(k);
            rd(`TDS_OFS_ALARM_HI, 6);
            `CHK(rbuf[0], {f[0][3:2], f[1][3:2], f[2][3:2], f[3][3:2]})
            `CHK(rbuf[1], {f[4][3:2], 6'h00})
            `CHK({rbuf[2], rbuf[3]}, 16'h0000)
            `CHK(rbuf[4], {f[0][1:0], f[1][1:0], f[2][1:0], f[3][1:0]})
            `CHK(rbuf[5], {f[4][1:0], 6'h00})
            rd(`TDS_OFS_LIVE_FIRST, 2);
            `CHK({rbuf[0], rbuf[1]}, mv[15:0])
            // Current-address read resumes after the last byte read, at the vcc MSB
            u_host.start();
            u_host.xfer({`TDS_DEV_ADDR, 1'b1}, 1'b1, q, ack);
            `CHK(ack, 1'b0)
            u_host.xfer(8'hff, 1'b1, q, ack);
            u_host.stop();
            `CHK(q, mv[31:24])
        end
        tally_and_finish();
    end
endmodule
bind tds_diag_bank tds_monitor u_mon (
    .sys_clk(sys_clk), .rst(rst), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .tx_disable_pin(tx_disable_pin),
    .rate_select_pin(rate_select_pin), .tx_disabled_q(tx_disabled_q),
    .rate_high_q(rate_high_q));
`default_nettype wire
